//--- common/ctm_regs.svh
// register offsets, field positions and reset values of the transceiver mode register
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define CTM_ADDR_W          7
`define CTM_DATA_W          16
`define CTM_ADDR_BUS_MODE   7'h04

// ****************************************************************
// mode field
// ****************************************************************
`define CTM_MODE_W          3
`define CTM_MODE_MSB        2
`define CTM_MODE_LSB        0
`define CTM_SWK_BIT         2
`define CTM_RES_W           13
`define CTM_RES_ZERO        13'h0000

// low two mode bits
`define CTM_LOW_OFF         2'h0
`define CTM_LOW_WAKE        2'h1
`define CTM_LOW_RECV        2'h2
`define CTM_LOW_NORM        2'h3

// ****************************************************************
// reset and forced values
// ****************************************************************
`define CTM_RESET_VAL       16'h0020
`define CTM_POR_MODE        3'h0
`define CTM_SWDEV_MODE      3'h1
`define CTM_FS_MODE         3'h1
`define CTM_RESTART_MSB     1'h0
`define CTM_RDATA_IDLE      16'h0000

`endif

//--- common/ctm_pkg.sv
// types shared by the transceiver mode register logic
package ctm_pkg;

    // ****************************************************************
    // transceiver operating mode, one-hot
    // ****************************************************************
    typedef enum logic [3:0] {
        CTM_XCVR_OFF     = 4'h1,
        CTM_XCVR_WAKE    = 4'h2,
        CTM_XCVR_RECEIVE = 4'h4,
        CTM_XCVR_NORMAL  = 4'h8
    } ctm_xcvr_t;

endpackage

//--- hw/ctm_mode_ctrl.sv
// transceiver mode register with device-initiated mode updates
`timescale 1ns/1ps
`include "ctm_regs.svh"
// Summary of operation
// - mode bits 2:0: 000 off, 001 wake, 010 receive only, 011 normal
// - 100 off; 101, 110, 111 are wake, receive, normal with selective wake
// - sleep and stop entry never change mode bit 2; host writes, restart, fail-safe, soft reset and power-on load do
// - bits 15:3 are reserved, ignore writes and read as zero
// - sleep entry with normal and error flag clear moves field to x01
// - sleep entry with receive only moves transceiver and field to wake
// - stop entry with receive only keeps transceiver and field unchanged
// - wake capable or off at sleep or stop entry stays unchanged
// - fail-safe entry forces the register to pattern 001, wake capable
// - restart clears everything but low mode bits, which follow the cause
// - software development mode loads 001 on power-on or soft reset

module ctm_mode_ctrl
    import ctm_pkg::*;
(
    input  wire logic                     clock,               // 10 MHz system clock
    input  wire logic                     reset,               // power-on reset, async
    input  wire logic                     host_wr_en,          // register write strobe
    input  wire logic                     host_rd_en,          // register read strobe
    input  wire logic [`CTM_ADDR_W-1:0]   host_addr,           // register address
    input  wire logic [`CTM_DATA_W-1:0]   host_wdata,          // write data
    output logic      [`CTM_DATA_W-1:0]   host_rdata,          // read data
    output logic                          host_rd_valid,       // read answer pulse
    input  wire logic                     sleep_entry,         // sleep mode entry pulse
    input  wire logic                     stop_entry,          // stop mode entry pulse
    input  wire logic                     failsafe_entry,      // fail-safe entry pulse
    input  wire logic                     system_error_enable, // error handling flag
    input  wire logic                     soft_reset,          // soft reset pulse
    input  wire logic                     restart,             // restart pulse
    input  wire logic [1:0]               restart_low_mode,    // low mode bits on restart
    input  wire logic                     sw_dev_mode,         // software development level
    output ctm_xcvr_t                     xcvr_mode,           // transceiver mode
    output logic                          selective_wake       // selective wake enabled
);

    // ****************************************************************
    // helper functions
    // ****************************************************************
    function automatic logic addr_hit(input logic [`CTM_ADDR_W-1:0] a);
        addr_hit = (a == `CTM_ADDR_BUS_MODE);
    endfunction

    function automatic ctm_xcvr_t decode_xcvr(input logic [1:0] low);
        ctm_xcvr_t m;
        m = CTM_XCVR_OFF;
        unique case (low)
            `CTM_LOW_OFF:  m = CTM_XCVR_OFF;
            `CTM_LOW_WAKE: m = CTM_XCVR_WAKE;
            `CTM_LOW_RECV: m = CTM_XCVR_RECEIVE;
            `CTM_LOW_NORM: m = CTM_XCVR_NORMAL;
        endcase
        decode_xcvr = m;
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [`CTM_MODE_W-1:0] mode_ff;
    logic [`CTM_MODE_W-1:0] nxt_mode_ff;
    logic                   init_ff;
    logic [`CTM_DATA_W-1:0] rdata_ff;
    logic [`CTM_DATA_W-1:0] nxt_rdata_ff;
    logic                   rd_valid_ff;

    // ****************************************************************
    // access decode
    // ****************************************************************
    wire       wr_hit   = host_wr_en && addr_hit(host_addr);
    wire       rd_hit   = host_rd_en && addr_hit(host_addr);
    wire [1:0] low_mode = mode_ff[1:0];
    wire       mode_msb = mode_ff[`CTM_MODE_MSB];

    // events that replace the whole field outrank mode entry and host writes
    wire override = restart || failsafe_entry || soft_reset || init_ff;

    // ****************************************************************
    // device-initiated updates
    // ****************************************************************
    wire sleep_norm = sleep_entry && (low_mode == `CTM_LOW_NORM)
                      && !system_error_enable;
    wire sleep_recv = sleep_entry && (low_mode == `CTM_LOW_RECV);
    wire sleep_move = !override && (sleep_norm || sleep_recv);
    // stop entry never touches the field, so receive only survives it
    // whether the host or a restart chose it beforehand

    // value loaded by power-on or soft reset
    wire [`CTM_MODE_W-1:0] por_mode = sw_dev_mode ? `CTM_SWDEV_MODE
                                                  : `CTM_POR_MODE;

    wire [`CTM_MODE_W-1:0] restart_mode = {`CTM_RESTART_MSB, restart_low_mode};
    wire [`CTM_MODE_W-1:0] sleep_mode   = {mode_msb, `CTM_LOW_WAKE};
    wire [`CTM_MODE_W-1:0] host_mode    =
        host_wdata[`CTM_MODE_MSB:`CTM_MODE_LSB];

    // a host write in the same cycle as a sleep entry that moves the field is lost on purpose:
    // the device must not leave sleep with the transceiver still active
    assign nxt_mode_ff = restart                   ? restart_mode      :
                         failsafe_entry            ? `CTM_FS_MODE      :
                         (soft_reset || init_ff)   ? por_mode          :
                         sleep_move                ? sleep_mode        :
                         wr_hit                    ? host_mode         :
                                                     mode_ff;

    // ****************************************************************
    // read path
    // ****************************************************************
    assign nxt_rdata_ff = rd_hit ? {`CTM_RES_ZERO, mode_ff}
                                 : `CTM_RDATA_IDLE;

    // ****************************************************************
    // flip-flops
    // ****************************************************************
    // the strap is sampled one edge after release and at soft reset, never under reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_ff <= `CTM_POR_MODE;
            init_ff <= 1'b1;
        end else begin
            mode_ff <= nxt_mode_ff;
            init_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_ff    <= `CTM_RDATA_IDLE;
            rd_valid_ff <= 1'b0;
        end else begin
            rdata_ff    <= nxt_rdata_ff;
            rd_valid_ff <= host_rd_en;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign host_rdata     = rdata_ff;
    assign host_rd_valid  = rd_valid_ff;
    assign xcvr_mode      = decode_xcvr(low_mode);
    assign selective_wake = mode_msb && (low_mode != `CTM_LOW_OFF);

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_DECODE_BASE: assert property (@(posedge clock) disable iff (reset)
        !mode_msb |-> (xcvr_mode == decode_xcvr(low_mode)) && !selective_wake)
        else $error("mode field without selective wake decoded wrongly");

    AST_DECODE_SWK: assert property (@(posedge clock) disable iff (reset)
        (mode_ff == 3'h7) |-> (xcvr_mode == CTM_XCVR_NORMAL) && selective_wake)
        else $error("normal with selective wake decoded wrongly");

    AST_MSB_HOST_ONLY: assert property (@(posedge clock) disable iff (reset)
        !$stable(mode_msb) |->
            $past(wr_hit || restart || failsafe_entry || soft_reset || init_ff))
        else $error("mode bit 2 changed without a host write or reset");

    AST_RES_ZERO: assert property (@(posedge clock) disable iff (reset)
        host_rd_valid |-> (host_rdata[`CTM_DATA_W-1:`CTM_MODE_W] == `CTM_RES_ZERO))
        else $error("reserved bits read as nonzero");

    AST_SLEEP_NORMAL: assert property (@(posedge clock) disable iff (reset)
        (sleep_entry && !system_error_enable && low_mode == `CTM_LOW_NORM && !override)
        |=> (mode_ff == {$past(mode_msb), `CTM_LOW_WAKE}) && (xcvr_mode == CTM_XCVR_WAKE))
        else $error("normal mode not moved to wake capable at sleep entry");

    AST_SLEEP_RECV: assert property (@(posedge clock) disable iff (reset)
        (sleep_entry && low_mode == `CTM_LOW_RECV && !override)
        |=> (mode_ff[1:0] == `CTM_LOW_WAKE) && (mode_msb == $past(mode_msb)))
        else $error("receive only not moved to wake capable at sleep entry");

    AST_STOP_RECV: assert property (@(posedge clock) disable iff (reset)
        (stop_entry && !sleep_entry && low_mode == `CTM_LOW_RECV && !override && !wr_hit)
        |=> (mode_ff == $past(mode_ff)) && (xcvr_mode == CTM_XCVR_RECEIVE))
        else $error("receive only left at stop entry");

    AST_KEEP_WAKE_OFF: assert property (@(posedge clock) disable iff (reset)
        ((sleep_entry || stop_entry) && !low_mode[1] && !override && !wr_hit)
        |=> $stable(mode_ff))
        else $error("wake capable or off changed at mode entry");

    AST_FAILSAFE: assert property (@(posedge clock) disable iff (reset)
        (failsafe_entry && !restart)
        |=> (mode_ff == `CTM_FS_MODE) && (xcvr_mode == CTM_XCVR_WAKE) && !selective_wake)
        else $error("fail-safe entry did not force wake capable");

    AST_RESTART: assert property (@(posedge clock) disable iff (reset)
        restart |=> (mode_ff == {`CTM_RESTART_MSB, $past(restart_low_mode)}))
        else $error("restart value wrong");

    AST_SWDEV: assert property (@(posedge clock) disable iff (reset)
        (soft_reset && sw_dev_mode && !restart && !failsafe_entry)
        |=> (mode_ff == `CTM_SWDEV_MODE))
        else $error("software development reset value not loaded");

    AST_READBACK: assert property (@(posedge clock) disable iff (reset)
        rd_hit |=> host_rd_valid && (host_rdata[`CTM_MODE_MSB:0] == $past(mode_ff)))
        else $error("readback differs from mode field");

    // ****************************************************************
    // further checks on decode, priorities and the read port
    // ****************************************************************
    // these catch a broken priority chain that the per-event checks above mask

    AST_XCVR_ONEHOT: assert property (@(posedge clock) disable iff (reset)
        $onehot(xcvr_mode))
        else $error("transceiver mode not one-hot");

    AST_OFF_CODES: assert property (@(posedge clock) disable iff (reset)
        (low_mode == `CTM_LOW_OFF) |-> (xcvr_mode == CTM_XCVR_OFF) && !selective_wake)
        else $error("off code decoded wrongly");

    AST_SWK_WAKE: assert property (@(posedge clock) disable iff (reset)
        (mode_ff == 3'h5) |-> (xcvr_mode == CTM_XCVR_WAKE) && selective_wake)
        else $error("wake capable with selective wake decoded wrongly");

    AST_SWK_RECV: assert property (@(posedge clock) disable iff (reset)
        (mode_ff == 3'h6) |-> (xcvr_mode == CTM_XCVR_RECEIVE) && selective_wake)
        else $error("receive only with selective wake decoded wrongly");

    AST_MSB_KEPT_SLEEP: assert property (@(posedge clock) disable iff (reset)
        (sleep_entry && !override && !wr_hit) |=> (mode_msb == $past(mode_msb)))
        else $error("mode bit 2 changed at sleep entry");

    AST_WRITE: assert property (@(posedge clock) disable iff (reset)
        (wr_hit && !override && !sleep_move) |=> (mode_ff == $past(host_mode)))
        else $error("host write not stored");

    AST_WR_MISS: assert property (@(posedge clock) disable iff (reset)
        (host_wr_en && !addr_hit(host_addr) && !override && !sleep_move)
        |=> $stable(mode_ff))
        else $error("write to another address changed the mode field");

    AST_RD_IDLE: assert property (@(posedge clock) disable iff (reset)
        !host_rd_valid |-> (host_rdata == `CTM_RDATA_IDLE))
        else $error("read data not idle outside a read answer");

    AST_RD_MISS: assert property (@(posedge clock) disable iff (reset)
        (host_rd_en && !addr_hit(host_addr)) |=> (host_rdata == `CTM_RDATA_IDLE))
        else $error("read of another address returned data");

    AST_SLEEP_ERR_KEEP: assert property (@(posedge clock) disable iff (reset)
        (sleep_entry && system_error_enable && low_mode == `CTM_LOW_NORM
         && !override && !wr_hit) |=> $stable(mode_ff))
        else $error("normal mode changed at sleep entry with error flag set");

    AST_SLEEP_RECV_XCVR: assert property (@(posedge clock) disable iff (reset)
        (sleep_entry && low_mode == `CTM_LOW_RECV && !override)
        |=> (xcvr_mode == CTM_XCVR_WAKE))
        else $error("transceiver not wake capable after sleep from receive only");

    AST_STOP_KEEP: assert property (@(posedge clock) disable iff (reset)
        (stop_entry && !sleep_entry && !override && !wr_hit) |=> $stable(mode_ff))
        else $error("stop entry changed the mode field");

    AST_POR_LOAD: assert property (@(posedge clock) disable iff (reset)
        (init_ff && !restart && !failsafe_entry)
        |=> (mode_ff == ($past(sw_dev_mode) ? `CTM_SWDEV_MODE : `CTM_POR_MODE)))
        else $error("power-on value not loaded after reset release");

    AST_SOFT_PLAIN: assert property (@(posedge clock) disable iff (reset)
        (soft_reset && !sw_dev_mode && !restart && !failsafe_entry)
        |=> (mode_ff == `CTM_POR_MODE))
        else $error("soft reset value not loaded");

    AST_INIT_ONCE: assert property (@(posedge clock) disable iff (reset)
        init_ff |=> !init_ff)
        else $error("power-on load repeated");

    AST_RD_VALID: assert property (@(posedge clock) disable iff (reset)
        host_rd_en |=> host_rd_valid)
        else $error("read strobe not answered");

    AST_RD_QUIET: assert property (@(posedge clock) disable iff (reset)
        !host_rd_en |=> !host_rd_valid)
        else $error("read answer without a read strobe");

    AST_FS_LOW: assert property (@(posedge clock) disable iff (reset)
        (failsafe_entry && !restart) |=> (low_mode == `CTM_LOW_WAKE))
        else $error("fail-safe entry left the low mode bits wrong");

endmodule // ctm_mode_ctrl

//--- tb/ctm_host_model.sv
// host side model driving the mode register port
`timescale 1ns/1ps
`include "ctm_regs.svh"
module ctm_host_model (
    input  wire logic                   clock,         // system clock
    output logic                        host_wr_en,    // write strobe
    output logic                        host_rd_en,    // read strobe
    output logic [`CTM_ADDR_W-1:0]      host_addr,     // register address
    output logic [`CTM_DATA_W-1:0]      host_wdata,    // write data
    input  wire logic [`CTM_DATA_W-1:0] host_rdata,    // read data
    input  wire logic                   host_rd_valid  // read answer
);
    initial begin
        host_wr_en = 1'h0;
        host_rd_en = 1'h0;
        host_addr  = 7'h7b;
        host_wdata = 16'hffff;
    end
    task automatic wr(input logic [`CTM_ADDR_W-1:0] a, input logic [`CTM_DATA_W-1:0] d);
        @(posedge clock);
        host_wr_en <= 1'h1;
        host_addr  <= a;
        host_wdata <= d;
        @(posedge clock);
        host_wr_en <= 1'h0;
        // released lines show the inverse, never the stale value
        host_addr  <= ~a;
        host_wdata <= ~d;
    endtask
    task automatic rd(input logic [`CTM_ADDR_W-1:0] a, output logic [`CTM_DATA_W-1:0] d,
                      output logic ok);
        int n;
        @(posedge clock);
        host_rd_en <= 1'h1;
        host_addr  <= a;
        @(posedge clock);
        host_rd_en <= 1'h0;
        host_addr  <= ~a;
        ok = 1'h0;
        d  = 16'h0000;
        for (n = 0; n < 4; n++) begin
            #1;
            if (host_rd_valid === 1'h1) begin
                d  = host_rdata;
                ok = 1'h1;
                break;
            end
            @(posedge clock);
        end
    endtask
endmodule // ctm_host_model

//--- tb/test_can_transceiver_mode_control.sv
// self-checking bench for the transceiver mode register
`timescale 1ns/1ps
`include "ctm_regs.svh"
module test_can_transceiver_mode_control import ctm_pkg::*; ;
    logic                   clock, reset, host_wr_en, host_rd_en, host_rd_valid;
    logic [`CTM_ADDR_W-1:0] host_addr;
    logic [`CTM_DATA_W-1:0] host_wdata, host_rdata;
    logic [4:0]             ev;    // restart, soft reset, fail-safe, stop, sleep
    logic                   system_error_enable, sw_dev_mode, selective_wake;
    logic [1:0]             restart_low_mode;
    ctm_xcvr_t              xcvr_mode;
    int                     mismatches, checked, seed, m, c, e;
    ctm_mode_ctrl u_dut (.clock(clock), .reset(reset), .host_wr_en(host_wr_en),
        .host_rd_en(host_rd_en), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_rd_valid(host_rd_valid), .sleep_entry(ev[0]),
        .stop_entry(ev[1]), .failsafe_entry(ev[2]), .system_error_enable(system_error_enable),
        .soft_reset(ev[3]), .restart(ev[4]), .restart_low_mode(restart_low_mode),
        .sw_dev_mode(sw_dev_mode), .xcvr_mode(xcvr_mode), .selective_wake(selective_wake));
    ctm_host_model u_host (.clock(clock), .host_wr_en(host_wr_en), .host_rd_en(host_rd_en),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rd_valid(host_rd_valid));
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_mode(input ctm_xcvr_t got, input ctm_xcvr_t exp,
                            input logic gsw, input logic esw);
        checked++;
        if (got !== exp || gsw !== esw) begin
            mismatches++;
            $display("Error at %0t: mode outputs wrong for %0d", $time, m);
        end
    endtask
    task automatic read_reg(input logic [6:0] a, output logic [15:0] d);
        logic ok;
        u_host.rd(a, d, ok);
        if (ok !== 1'h1) begin
            mismatches++;
            $display("Error at %0t: read answer missing", $time);
            stop_test();
        end
    endtask
    task automatic check_all();
        logic [15:0] d;
        logic        sw;
        sw = m[2] & (m[1:0] != 2'h0);
        read_reg(`CTM_ADDR_BUS_MODE, d);
        cmp_word(d, 16'(m));
        cmp_mode(xcvr_mode, ctm_xcvr_t'(4'h1 << m[1:0]), selective_wake, sw);
    endtask
    task automatic pulse(input logic [4:0] v);
        @(posedge clock);
        ev <= v;
        @(posedge clock);
        ev <= 5'h00;
    endtask
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    initial begin
        logic [15:0] d;
        seed = 32'h2f3b;
        {mismatches, checked, m} = '0;
        {reset, ev, system_error_enable, restart_low_mode, sw_dev_mode} = 10'h200;
        repeat (12) @(posedge clock);
        reset <= 1'h0;
        repeat (2) @(posedge clock);
        check_all();
        for (c = 0; c < 8; c++) begin
            d = 16'($random(seed));
            d[2:0] = 3'(c);
            u_host.wr(`CTM_ADDR_BUS_MODE, d);
            m = c;
            check_all();
        end
        $display("test mode codes done");
        // e: sleep with error flag clear, sleep with flag set, stop
        for (e = 0; e < 3; e++) begin
            for (c = 0; c < 8; c++) begin
                u_host.wr(`CTM_ADDR_BUS_MODE, 16'(c));
                m = c;
                system_error_enable <= (e == 1);
                pulse((e == 2) ? 5'h02 : 5'h01);
                if (e != 2 && (c % 4 == 2 || (c % 4 == 3 && e == 0)))
                    m = (c & 4) | 1;
                check_all();
            end
        end
        $display("test sleep and stop done");
        u_host.wr(`CTM_ADDR_BUS_MODE, 16'h0007);
        pulse(5'h04);
        m = 1;
        check_all();
        for (c = 0; c < 4; c++) begin
            u_host.wr(`CTM_ADDR_BUS_MODE, 16'h0007);
            restart_low_mode <= 2'($random(seed));
            pulse(5'h10);
            m = restart_low_mode;
            check_all();
        end
        for (c = 0; c < 2; c++) begin
            u_host.wr(`CTM_ADDR_BUS_MODE, 16'h0006);
            sw_dev_mode <= c[0];
            pulse(5'h08);
            m = c;
            check_all();
        end
        $display("test device events done");
        reset <= 1'h1;
        repeat (2) @(posedge clock);
        reset <= 1'h0;
        repeat (2) @(posedge clock);
        check_all();
        u_host.wr(7'h05, 16'h0003);
        read_reg(7'h05, d);
        cmp_word(d, 16'h0000);
        check_all();
        $display("test reset and unmapped done");
        stop_test();
    end
endmodule // test_can_transceiver_mode_control
